/* shared/bfcp_pkg.sv */
package bfcp_pkg;
    // ==========================================================
    // Register map (byte addresses on the word bus)
    localparam logic [7:0]  ADDR_BREAK_CFG   = 8'h78;
    localparam logic [7:0]  ADDR_PAIR0_PROT  = 8'h7C;
    localparam logic [7:0]  ADDR_PAIR1_PROT  = 8'h80;
    localparam logic [7:0]  ADDR_COMMON_CTL  = 8'h90;
    localparam logic [7:0]  ADDR_STATUS      = 8'h94;
    localparam logic [31:0] RESET_WORD       = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_WORD    = 32'h0000_0000;
    // ==========================================================
    // Field positions
    localparam int BRK_FILT_W      = 4;
    localparam int BRK_POL_BASE    = 25;
    localparam int BRK_EN_BASE     = 24;
    localparam int SEL_BIT         = 31;
    localparam int RUN_BIT         = 11;
    localparam int IDLE_BIT        = 10;
    localparam int DT_LSB          = 0;
    localparam int DT_W            = 8;
    localparam logic [31:0] BRK_CFG_MASK  = 32'hFF00_FFFF;
    localparam logic [31:0] PROT_MASK     = 32'h8000_0CFF;
    localparam logic [31:0] LOCKED_SEL_DT = 32'h8000_00FF;
    localparam logic [31:0] OFFSTATE_MASK = 32'h0000_0C00;
    // Common control word layout (own register)
    localparam int CC_DT_LSB   = 0;
    localparam int CC_IDLE_BIT = 10;
    localparam int CC_RUN_BIT  = 11;
    localparam int CC_LOCK_LSB = 12;
    localparam int CC_PRIMARY_OUTPUT_ENABLE_BIT = 16;
    localparam int CC_DTS_LSB  = 20;
    localparam logic [31:0] CC_MASK = 32'h00F3_3CFF;
    // ==========================================================
    // Lock levels
    localparam logic [1:0] LOCK_OPEN = 2'h0;
    localparam logic [1:0] LOCK_L2   = 2'h2;
    // Dead-time base divider width (ticks of sys_clk per base period)
    localparam int DTS_DIV_W = 4;
    localparam int CNT_W     = 14;
    localparam int PRE_W     = 5;
    // ==========================================================
    typedef struct packed {
        logic       polarity;
        logic       enable;
        logic [3:0] code;
    } bfcp_fault_cfg_t;

    typedef struct packed {
        logic       select;
        logic       runOff;
        logic       idleOff;
        logic [7:0] deadtime;
    } bfcp_pair_cfg_t;

    typedef enum logic [2:0] {
        PH_OFF  = 3'h1,
        PH_DEAD = 3'h2,
        PH_ON   = 3'h4
    } bfcp_phase_t;

    // Sample prescale exponent (0: timer clock) and event count per code
    function automatic logic [2:0] filtDivExp(input logic [3:0] c);
        case (c)
            4'h0, 4'h1, 4'h2, 4'h3: filtDivExp = 3'h0;
            4'h4, 4'h5:             filtDivExp = 3'h1;
            4'h6, 4'h7:             filtDivExp = 3'h2;
            4'h8, 4'h9:             filtDivExp = 3'h3;
            4'hA, 4'hB, 4'hC:       filtDivExp = 3'h4;
            default:                filtDivExp = 3'h5;
        endcase
    endfunction

    function automatic logic [3:0] filtCount(input logic [3:0] c);
        case (c)
            4'h0:                   filtCount = 4'h1;
            4'h1:                   filtCount = 4'h2;
            4'h2:                   filtCount = 4'h4;
            4'h4, 4'h6, 4'h8,
            4'hB, 4'hE:             filtCount = 4'h6;
            4'hA, 4'hD:             filtCount = 4'h5;
            default:                filtCount = 4'h8;
        endcase
    endfunction

    // Dead time in base-clock periods
    function automatic logic [CNT_W-1:0] deadTicks(input logic [7:0] d);
        casez (d[7:5])
            3'b0??:  deadTicks = {6'h00, d};
            3'b10?:  deadTicks = CNT_W'({8'h00, 6'h00} | ((14'h0040 + {8'h00, d[5:0]}) << 1));
            3'b110:  deadTicks = CNT_W'((14'h0020 + {9'h000, d[4:0]}) << 3);
            default: deadTicks = CNT_W'((14'h0020 + {9'h000, d[4:0]}) << 4);
        endcase
    endfunction
endpackage

/* rtl/bfcp_top.sv */
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module bfcp_top
    import bfcp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [3:0]  faultIn,
    input  wire logic [1:0]  pairMainRef,
    input  wire logic [1:0]  pairMainEnable,
    input  wire logic [1:0]  pairCompEnable,
    output logic [3:0]       faultActive,
    output logic [1:0]       pairMainOutput,
    output logic [1:0]       pairCompOutput
);
    // ==========================================================
    // Register storage
    logic [31:0] breakCfg;
    logic [31:0] pairProt [2];
    logic [31:0] commonCtl;
    logic        ackPending;

    wire logic [1:0]  lockLevel  = commonCtl[CC_LOCK_LSB +: 2];
    wire logic        lockOpen   = (lockLevel == LOCK_OPEN);
    wire logic        offFrozen  = (lockLevel >= LOCK_L2);
    wire logic        fullWord   = (avs_byteenable == 4'hF);
    wire logic        busReq     = (avs_read | avs_write) & ~ackPending;
    wire logic        doWrite    = avs_write & ackPending & fullWord & clk_en;
    wire logic        hitBrk     = (avs_address == ADDR_BREAK_CFG);
    wire logic        hitP0      = (avs_address == ADDR_PAIR0_PROT);
    wire logic        hitP1      = (avs_address == ADDR_PAIR1_PROT);
    wire logic        hitCc      = (avs_address == ADDR_COMMON_CTL);
    wire logic        hitSt      = (avs_address == ADDR_STATUS);

    // Writable-bit masks per lock level
    wire logic [31:0] brkWrMask  = lockOpen ? BRK_CFG_MASK : RESET_WORD;
    wire logic [31:0] protWrMask = (lockOpen ? LOCKED_SEL_DT : RESET_WORD)
                                 | (offFrozen ? RESET_WORD : OFFSTATE_MASK);
    wire logic [31:0] nextBrk    = (breakCfg & ~brkWrMask) | (avs_writedata & brkWrMask);
    wire logic [31:0] nextP0     = (pairProt[0] & ~protWrMask) | (avs_writedata & protWrMask);
    wire logic [31:0] nextP1     = (pairProt[1] & ~protWrMask) | (avs_writedata & protWrMask);
    wire logic [31:0] nextCc     = avs_writedata & CC_MASK;

    // Read mux
    wire logic [31:0] statusWord = {24'h000000, 2'h0, pairMainOutput, faultActive};
    wire logic [31:0] next_readdata = hitBrk ? breakCfg :
                                      hitP0  ? pairProt[0] :
                                      hitP1  ? pairProt[1] :
                                      hitCc  ? commonCtl :
                                      hitSt  ? statusWord : UNMAPPED_WORD;

    // ==========================================================
    // Avalon slave: one wait cycle, answer on the second edge
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ackPending      <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= RESET_WORD;
        end else if (clk_en) begin
            ackPending      <= busReq;
            avs_waitrequest <= ~busReq;
            if (busReq && avs_read) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    // Register updates; lock level can be written freely here
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            breakCfg    <= RESET_WORD;
            pairProt[0] <= RESET_WORD;
            pairProt[1] <= RESET_WORD;
            commonCtl   <= RESET_WORD;
        end else if (doWrite) begin
            if (hitBrk) breakCfg <= nextBrk;
            if (hitP0) pairProt[0] <= nextP0;
            if (hitP1) pairProt[1] <= nextP1;
            if (hitCc) commonCtl <= nextCc;
        end
    end

    // ==========================================================
    // Dead-time base clock: tick every (divider+1) sys_clk cycles
    logic [DTS_DIV_W-1:0] dtsCnt;
    logic [PRE_W-1:0]     prescale;
    wire logic [DTS_DIV_W-1:0] dtsDiv = commonCtl[CC_DTS_LSB +: DTS_DIV_W];
    wire logic dtsTick = (dtsCnt == dtsDiv);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            dtsCnt   <= '0;
            prescale <= '0;
        end else if (clk_en) begin
            dtsCnt <= dtsTick ? '0 : dtsCnt + 1'b1;
            if (dtsTick) prescale <= prescale + 1'b1;
        end
    end

    // ==========================================================
    // Fault filters, one per input
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : gFault
            bfcp_fault_cfg_t cfg;
            logic [3:0] evCnt;
            logic       level;
            logic [2:0] divExp;
            logic [PRE_W-1:0] preMask;
            logic       sampleEn;
            logic       rawActive;
            logic [3:0] needCnt;
            assign cfg.polarity = breakCfg[BRK_POL_BASE + 2*gi];
            assign cfg.enable   = breakCfg[BRK_EN_BASE + 2*gi];
            assign cfg.code     = breakCfg[BRK_FILT_W*gi +: BRK_FILT_W];
            assign rawActive    = cfg.polarity ? faultIn[gi] : ~faultIn[gi];
            assign divExp       = filtDivExp(cfg.code);
            assign needCnt      = filtCount(cfg.code);
            assign preMask      = PRE_W'((6'h01 << divExp) - 6'h01);
            // Divided rates sample on base ticks at aligned prescale counts
            assign sampleEn     = (divExp == 3'h0) ? 1'b1 :
                                  (dtsTick && ((prescale & preMask) == preMask));

            // Candidate check: a mismatch restarts the count
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    evCnt <= 4'h0;
                    level <= 1'b0;
                end else if (clk_en && sampleEn) begin
                    if (rawActive == level) begin
                        evCnt <= 4'h0;
                    end else if (evCnt + 1'b1 >= needCnt) begin
                        level <= rawActive;
                        evCnt <= 4'h0;
                    end else begin
                        evCnt <= evCnt + 1'b1;
                    end
                end
            end

            // Disabled inputs never report
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    faultActive[gi] <= 1'b0;
                end else if (clk_en) begin
                    faultActive[gi] <= cfg.enable &
                        ((cfg.code == 4'h0) ? rawActive : level);
                end
            end
        end
    endgenerate

    // ==========================================================
    // Complementary pair output stages
    wire logic primaryEn = commonCtl[CC_PRIMARY_OUTPUT_ENABLE_BIT];
    generate
        for (gi = 0; gi < 2; gi++) begin : gPair
            bfcp_pair_cfg_t act;
            bfcp_phase_t    phase;
            logic [CNT_W-1:0] dtRemain;
            logic             lastRef;
            logic             allowed;
            logic [CNT_W-1:0] dtLoad;
            // Per-pair register wins only when its select bit is set
            assign act.select   = pairProt[gi][SEL_BIT];
            assign act.runOff   = act.select ? pairProt[gi][RUN_BIT] : commonCtl[CC_RUN_BIT];
            assign act.idleOff  = act.select ? pairProt[gi][IDLE_BIT] : commonCtl[CC_IDLE_BIT];
            assign act.deadtime = act.select ? pairProt[gi][DT_LSB +: DT_W]
                                             : commonCtl[CC_DT_LSB +: DT_W];
            assign allowed      = primaryEn ? act.runOff : act.idleOff;
            assign dtLoad       = deadTicks(act.deadtime);

            // Each reference edge passes through a dead phase with both low
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    phase    <= PH_OFF;
                    dtRemain <= '0;
                    lastRef  <= 1'b0;
                end else if (clk_en) begin
                    lastRef <= pairMainRef[gi];
                    case (phase)
                        PH_OFF: begin
                            if (allowed) begin
                                phase    <= PH_DEAD;
                                dtRemain <= dtLoad;
                            end
                        end
                        PH_DEAD: begin
                            if (!allowed) begin
                                phase <= PH_OFF;
                            end else if (dtRemain == '0) begin
                                phase <= PH_ON;
                            end else if (dtsTick) begin
                                dtRemain <= dtRemain - 1'b1;
                            end
                        end
                        PH_ON: begin
                            if (!allowed) begin
                                phase <= PH_OFF;
                            end else if (pairMainRef[gi] != lastRef) begin
                                phase    <= PH_DEAD;
                                dtRemain <= dtLoad;
                            end
                        end
                        default: phase <= PH_OFF;
                    endcase
                end
            end

            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    pairMainOutput[gi] <= 1'b0;
                    pairCompOutput[gi] <= 1'b0;
                end else if (clk_en) begin
                    pairMainOutput[gi] <= (phase == PH_ON) & pairMainEnable[gi] & lastRef;
                    pairCompOutput[gi] <= (phase == PH_ON) & pairCompEnable[gi] & ~lastRef;
                end
            end
        end
    endgenerate
endmodule

/* verif/bfcp_assertions.sv */
`timescale 1ns/1ps
// ============================================================
// Bus handshake and gate output checks at the top ports
module bfcp_assertions (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  pairMainEnable,
    input wire logic [1:0]  pairCompEnable,
    input wire logic [3:0]  faultActive,
    input wire logic [1:0]  pairMainOutput,
    input wire logic [1:0]  pairCompOutput
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // A request is taken only while no ack is pending
    wire logic busReq = avs_read | avs_write;
    property p_ack_next;
        busReq && avs_waitrequest && clk_en |=> !avs_waitrequest;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack one cycle after request");
    property p_ack_pulse;
        !avs_waitrequest && clk_en |=> avs_waitrequest;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over one cycle");
    property p_reset_idle;
        disable iff (1'b0) !reset_n && clk_en |=> avs_waitrequest && faultActive == 4'h0
            && pairMainOutput == 2'h0 && pairCompOutput == 2'h0;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");
    property p_no_overlap;
        (pairMainOutput & pairCompOutput) == 2'h0;
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both gates of a pair on");
    property p_rdata_hold;
        !avs_read |=> $stable(avs_readdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
    // Clock enable low must freeze every fault flag and gate output
    property p_freeze;
        !clk_en |=> $stable(faultActive) && $stable(pairMainOutput) && $stable(pairCompOutput);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
    property p_main_gate;
        $rose(pairMainOutput[0]) |-> $past(pairMainEnable[0]);
    endproperty
    a_main_gate: assert property (p_main_gate) else $error("main gate on while disabled");
    property p_comp_gate;
        $rose(pairCompOutput[1]) |-> $past(pairCompEnable[1]);
    endproperty
    a_comp_gate: assert property (p_comp_gate) else $error("comp gate on while disabled");
endmodule

/* verif/bfcp_power_stage.sv */
`timescale 1ns/1ps
// ============================================================
// Power stage: fault sources, reference PWM, shoot-through watch
module bfcp_power_stage #(
    parameter int HALF = 600
) (
    input  wire logic       sys_clk,
    input  wire logic [3:0] faultOn,
    input  wire logic [3:0] activeHigh,
    input  wire logic       refRun,
    input  wire logic [1:0] gateMain,
    input  wire logic [1:0] gateComp,
    output logic [3:0]      faultIn,
    output logic [1:0]      pairMainRef,
    output int              shootCount
);
    int phaseCnt = 0;
    // Fault line sits at its active level only while asserted
    assign faultIn = ~(faultOn ^ activeHigh);
    initial pairMainRef = 2'h0;
    initial shootCount = 0;
    // Reference held low when stopped; both gates on would short the bridge
    always @(posedge sys_clk) begin
        phaseCnt <= (phaseCnt == HALF - 1) ? 0 : phaseCnt + 1;
        if (!refRun)
            pairMainRef <= 2'h0;
        else if (phaseCnt == HALF - 1)
            pairMainRef <= ~pairMainRef;
        if ((gateMain & gateComp) != 2'h0)
            shootCount <= shootCount + 1;
    end
endmodule

/* verif/tb_bfcp_top.sv */
`timescale 1ns/1ps
bind bfcp_top bfcp_assertions u_bfcp_assertions (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pairMainEnable(pairMainEnable), .pairCompEnable(pairCompEnable), .faultActive(faultActive),
    .pairMainOutput(pairMainOutput), .pairCompOutput(pairCompOutput));
// ============================================================
// Bench: register access, fault filters and pair gating
module tb_bfcp_top
    import bfcp_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        clk_en = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest, seen;
    logic [3:0]  faultOn = 4'h0, activeHigh = 4'h0, faultIn, faultActive;
    logic        refRun = 1'b0;
    logic [1:0]  mainEn = 2'h3, compEn = 2'h3, mainRef, mainOut, compOut;
    int          failCount = 0, nChecks = 0, shootCount, cnt;
    // Event counts and sample dividers per filter code; dead-time codes and their tick counts
    int          nTab[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
    int          dTab[16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
    logic [7:0]  dtCode[4] = '{8'h05, 8'h81, 8'hC1, 8'hE0};
    int          dtTicks[4] = '{5, 130, 264, 512};
    logic [31:0] ccTab[5] = '{32'h0001_0000, 32'h0, 32'h0, 32'h0000_0400, 32'h0001_0000};
    logic [31:0] pTab[5] = '{32'h8000_0005, 32'h8000_0405, 32'h0000_0C05, 32'h0000_0C05, 32'h8000_0805};
    logic        seenTab[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    initial forever #2.5 sys_clk = ~sys_clk;
    bfcp_top u_bfcp_top (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .faultIn(faultIn), .pairMainRef(mainRef), .pairMainEnable(mainEn), .pairCompEnable(compEn),
        .faultActive(faultActive), .pairMainOutput(mainOut), .pairCompOutput(compOut));
    bfcp_power_stage #(.HALF(600)) u_bfcp_power_stage (.sys_clk(sys_clk), .faultOn(faultOn),
        .activeHigh(activeHigh), .refRun(refRun), .gateMain(mainOut), .gateComp(compOut),
        .faultIn(faultIn), .pairMainRef(mainRef), .shootCount(shootCount));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is sampled low; one idle edge after release
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        cnt = 0;
        do begin
            @(posedge sys_clk);
            cnt++;
        end while (avs_waitrequest !== 1'b0 && cnt < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (cnt >= 50) failCount++;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic waitAct(input logic lvl, input int lim);
        cnt = 0;
        while (faultActive[0] !== lvl && cnt < lim) begin
            @(posedge sys_clk);
            cnt++;
        end
    endtask
    // Edges from reference rise to main gate on
    task automatic deadGap(input int exp);
        wait (mainRef[0] === 1'b0);
        wait (mainRef[0] === 1'b1);
        cnt = 0;
        while (mainOut[0] !== 1'b1 && cnt < 2000) begin
            @(posedge sys_clk);
            cnt++;
        end
        check({31'h0, cnt >= exp && cnt <= exp + 6}, 32'h1);
    endtask
    task automatic watch(input int n);
        seen = 1'b0;
        // Let the gates settle from the previous setting, else a stale pulse is counted
        repeat (3) @(posedge sys_clk);
        repeat (n) begin
            @(posedge sys_clk);
            seen = seen | mainOut[0] | compOut[0];
        end
    endtask
    task automatic stopTest;
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Hang guard, well above the expected run length
    initial begin
        #250_000;
        failCount++;
        stopTest();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rchk(ADDR_BREAK_CFG, 32'h0);
        rchk(ADDR_PAIR0_PROT, 32'h0);
        rchk(8'h40, 32'h0);
        wr(ADDR_BREAK_CFG, 32'hFFFF_FFFF);
        rchk(ADDR_BREAK_CFG, 32'hFF00_FFFF);
        wr(ADDR_PAIR1_PROT, 32'hFFFF_FFFF);
        rchk(ADDR_PAIR1_PROT, 32'h8000_0CFF);
        wr(ADDR_PAIR0_PROT, 32'hFFFF_FFFF);
        // Partial write must be refused
        avs_byteenable <= 4'h1;
        wr(ADDR_PAIR0_PROT, 32'h0);
        avs_byteenable <= 4'hF;
        rchk(ADDR_PAIR0_PROT, 32'h8000_0CFF);
        // Lock 01 freezes break fields, select and dead time; lock 10 the off-state bits too
        wr(ADDR_COMMON_CTL, 32'h0000_1000);
        wr(ADDR_BREAK_CFG, 32'h0);
        rchk(ADDR_BREAK_CFG, 32'hFF00_FFFF);
        wr(ADDR_PAIR0_PROT, 32'h0);
        rchk(ADDR_PAIR0_PROT, 32'h8000_00FF);
        wr(ADDR_COMMON_CTL, 32'h0000_2000);
        wr(ADDR_PAIR0_PROT, 32'h0000_0C00);
        rchk(ADDR_PAIR0_PROT, 32'h8000_00FF);
        wr(ADDR_COMMON_CTL, 32'h0);
        // All inputs active high, input 3 on its slowest filter, input 0 disabled
        wr(ADDR_BREAK_CFG, 32'hFE00_F000);
        activeHigh <= 4'hF;
        faultOn <= 4'hF;
        repeat (10) @(posedge sys_clk);
        check({28'h0, faultActive}, 32'h6);
        // Status mirrors the filtered faults; both pairs have their main gate off here
        rchk(ADDR_STATUS, 32'h0000_0006);
        faultOn <= 4'h0;
        activeHigh <= 4'h0;
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_BREAK_CFG, 32'h0100_0000 | 32'(c));
            faultOn[0] <= 1'b1;
            waitAct(1'b1, 600);
            check({31'h0, cnt >= (nTab[c] - 1) * dTab[c] + 1 && cnt <= nTab[c] * dTab[c] + 6}, 32'h1);
            faultOn[0] <= 1'b0;
            waitAct(1'b0, 600);
        end
        // Bursts two samples short of the count must not pass
        wr(ADDR_BREAK_CFG, 32'h0100_0003);
        repeat (3) begin
            faultOn[0] <= 1'b1;
            repeat (6) @(posedge sys_clk);
            faultOn[0] <= 1'b0;
            @(posedge sys_clk);
        end
        repeat (10) @(posedge sys_clk);
        check({31'h0, faultActive[0]}, 32'h0);
        wr(ADDR_PAIR1_PROT, 32'h8000_0803);
        wr(ADDR_COMMON_CTL, 32'h0001_0000);
        refRun <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_PAIR0_PROT, 32'h8000_0800 | 32'(dtCode[i]));
            deadGap(dtTicks[i]);
        end
        // Reference is high and pair 1 is past its short dead time: main on, comp off
        check({30'h0, mainOut[1], compOut[1]}, 32'h2);
        // Base period of two clocks doubles the gap of five ticks
        wr(ADDR_COMMON_CTL, 32'h0011_0000);
        wr(ADDR_PAIR0_PROT, 32'h8000_0805);
        deadGap(10);
        clk_en <= 1'b0;
        repeat (30) @(posedge sys_clk);
        clk_en <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            mainEn[0] <= (i != 4);
            compEn[0] <= (i != 4);
            wr(ADDR_COMMON_CTL, ccTab[i]);
            wr(ADDR_PAIR0_PROT, pTab[i]);
            watch(1300);
            check({31'h0, seen}, {31'h0, seenTab[i]});
        end
        check(32'(shootCount), 32'h0);
        stopTest();
    end
endmodule
